// file: core/dual_fifo_flag_config_regs.sv
// Flag generation, flag routing and configuration registers of a dual FIFO.
// Assumes fill counts and pointer-based counts come from the pointer logic
// on clk_i; general-purpose pins and the DMA request pin arrive asynchronously.
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps

// Overview of operation
// - Eight internal flags, four per direction, from its fill level.
// - Four 10-bit offset registers set thresholds; upper bits ignored.
// - Reset or software reset-all clears the four offsets to zero.
// - Empty and full lag their almost flags; never switch coincidently.
// - Each flag pin shows a flag picked by its 4-bit routing field.
// - Routing code low three bits select flag; top bit ignored.
// - Status word: DMA direction bit 3, flags in bits 4-7, 12-15.
// - Control bit 0 picks separate strobes or data strobe plus direction.
// - Control bit 2 picks read or reread pointer for downstream full.
// - Control bit 3 picks write or rewrite pointer for upstream empty.
// - Control bits 7-6 give 2 to 5 clocks request to acknowledge.
// - Control bit 8 sets strobe length of one or two clocks.
// - Control bit 9 divides the internal DMA clock by two.
// - Control bit 10 makes port control pins outputs in peripheral mode.
// - Control bits 4 and 5 set request and acknowledge pin polarity.
// - Flags follow fill count against zero, n, depth minus m, depth.
// - Direction bits make pins outputs; data bits drive or capture.
module dual_fifo_flag_config_regs
  import dual_fifo_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:2]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [10:0] down_fill_i,
  input  wire logic [10:0] down_fill_reread_i,
  input  wire logic [10:0] up_fill_i,
  input  wire logic [10:0] up_fill_rewrite_i,
  input  wire logic        dma_dir_i,
  input  wire logic        reset_all_i,
  input  wire logic        dma_req_pin_i,
  input  wire logic        dma_ack_int_i,
  output logic             dma_req_o,
  output logic             dma_ack_pin_o,
  input  wire logic [5:0]  gp_pin_i,
  output logic      [5:0]  gp_pin_o,
  output logic      [5:0]  gp_pin_oe_o,
  output logic             flag_pin_a_o,
  output logic             flag_pin_b_o,
  output logic             flag_pin_c_o,
  output logic             flag_pin_d_o,
  output logic             port2_ds_style_o,
  output logic             port2_ctrl_oe_o,
  output logic      [2:0]  req_ack_clocks_o,
  output logic      [1:0]  strobe_clocks_o,
  output logic             dma_tick_o,
  output logic             irq_o
);

  typedef struct packed {
    logic [9:0]  dae;
    logic [9:0]  daf;
    logic [9:0]  uae;
    logic [9:0]  uaf;
    logic [15:0] route;
    logic [10:0] ctrl;
    logic [5:0]  gp_data;
    logic [5:0]  gp_dir;
    logic [7:0]  irq_st;
    logic [7:0]  irq_mask;
    logic        irq;
    logic        ack;
    logic [15:0] rdata;
    logic [3:0]  cmp_ef;
    logic [7:0]  flags;
    logic [3:0]  pins;
    logic [6:0]  sync1;
    logic [6:0]  sync2;
    logic [6:0]  sync3;
    logic [6:0]  sync_val;
    logic        req;
    logic        ack_pin;
    logic        div;
    logic        tick;
    logic [2:0]  req_ack_clks;
    logic [1:0]  strobe_clks;
  } state_t;

  state_t s;
  state_t next_s;

  // Byte-lane merge of a 16-bit register; lanes 2 and 3 carry nothing
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wr,
                                          input logic [3:0]  sel);
    merge16 = old_v;
    if (sel[0]) begin
      merge16[7:0] = wr[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = wr[15:8];
    end
  endfunction : merge16

  // Routing code to flag; the top code bit is a don't care
  function automatic logic route_sel(input logic [3:0] code,
                                     input logic [7:0] fl);
    route_sel = fl[code[2:0]];
  endfunction : route_sel

  logic [10:0] down_full_cnt;
  logic [10:0] up_empty_cnt;
  logic [15:0] status_word;
  logic [15:0] gp_read;
  logic        req_hit;
  logic        wr_now;
  logic        rd_now;
  logic [5:0]  byte_adr;
  logic [7:0]  rise;

  // Pointer pair used by the full and empty definitions
  always_comb begin
    down_full_cnt = s.ctrl[CTL_FULL_DEF] ? down_fill_reread_i
                                         : down_fill_i;
    up_empty_cnt  = s.ctrl[CTL_EMPTY_DEF] ? up_fill_rewrite_i
                                          : up_fill_i;
  end

  // Status and readback words; reserved bits stay zero
  always_comb begin
    status_word             = 16'h0000;
    status_word[ST_DMA_DIR] = dma_dir_i;
    status_word[ST_DE]      = s.flags[FL_DE];
    status_word[ST_DAE]     = s.flags[FL_DAE];
    status_word[ST_UF]      = s.flags[FL_UF];
    status_word[ST_UAF]     = s.flags[FL_UAF];
    status_word[ST_DF]      = s.flags[FL_DF];
    status_word[ST_DAF]     = s.flags[FL_DAF];
    status_word[ST_UE]      = s.flags[FL_UE];
    status_word[ST_UAE]     = s.flags[FL_UAE];
    // Inputs read the filtered pin, outputs read the latch
    gp_read = {10'h000, (s.gp_dir & s.gp_data) |
                        (~s.gp_dir & s.sync_val[5:0])};
  end

  // Bus decode; a write lands on the edge where the master sees ack
  always_comb begin
    byte_adr = {wb_adr_i, 2'b00};
    req_hit  = wb_cyc_i & wb_stb_i;
    wr_now   = req_hit & s.ack & wb_we_i;
    rd_now   = req_hit & s.ack & ~wb_we_i;
  end

  always_comb begin
    next_s = s;
    rise   = 8'h00;

    // Ack for one cycle per request, then drop
    next_s.ack = req_hit & ~s.ack;
    if (req_hit & ~s.ack) begin
      unique case (byte_adr)
        OFS_STATUS:   next_s.rdata = status_word;
        OFS_DOWN_AE:  next_s.rdata = {6'h00, s.dae};
        OFS_DOWN_AF:  next_s.rdata = {6'h00, s.daf};
        OFS_UP_AE:    next_s.rdata = {6'h00, s.uae};
        OFS_UP_AF:    next_s.rdata = {6'h00, s.uaf};
        OFS_ROUTE:    next_s.rdata = s.route;
        OFS_CTRL:     next_s.rdata = {5'h00, s.ctrl};
        OFS_GP_DATA:  next_s.rdata = gp_read;
        OFS_GP_DIR:   next_s.rdata = {10'h000, s.gp_dir};
        OFS_IRQ_STAT: next_s.rdata = {8'h00, s.irq_st};
        OFS_IRQ_MASK: next_s.rdata = {8'h00, s.irq_mask};
        default:      next_s.rdata = 16'h0000; // Unmapped reads zero
      endcase
    end

    // Register writes; bits above a field are dropped
    if (wr_now) begin
      unique case (byte_adr)
        OFS_DOWN_AE:  next_s.dae = 10'(merge16({6'h00, s.dae},
                                               wb_dat_i, wb_sel_i));
        OFS_DOWN_AF:  next_s.daf = 10'(merge16({6'h00, s.daf},
                                               wb_dat_i, wb_sel_i));
        OFS_UP_AE:    next_s.uae = 10'(merge16({6'h00, s.uae},
                                               wb_dat_i, wb_sel_i));
        OFS_UP_AF:    next_s.uaf = 10'(merge16({6'h00, s.uaf},
                                               wb_dat_i, wb_sel_i));
        OFS_ROUTE:    next_s.route = merge16(s.route, wb_dat_i, wb_sel_i);
        OFS_CTRL:     next_s.ctrl = 11'(merge16({5'h00, s.ctrl},
                                                wb_dat_i, wb_sel_i));
        OFS_GP_DATA:  next_s.gp_data = 6'(merge16({10'h000, s.gp_data},
                                                  wb_dat_i, wb_sel_i));
        OFS_GP_DIR:   next_s.gp_dir = 6'(merge16({10'h000, s.gp_dir},
                                                 wb_dat_i, wb_sel_i));
        OFS_IRQ_MASK: next_s.irq_mask = 8'(merge16({8'h00, s.irq_mask},
                                                   wb_dat_i, wb_sel_i));
        default:      next_s.route = s.route; // Writes elsewhere ignored
      endcase
    end
    // Unused control bit 1 holds zero whatever was written
    next_s.ctrl[1] = 1'b0;

    // Software reset-all returns every configuration register but the interrupt mask to default
    if (reset_all_i) begin
      next_s.dae     = RST_OFFSET;
      next_s.daf     = RST_OFFSET;
      next_s.uae     = RST_OFFSET;
      next_s.uaf     = RST_OFFSET;
      next_s.route   = RST_ROUTE;
      next_s.ctrl    = RST_CTRL;
      next_s.gp_data = RST_GP;
      next_s.gp_dir  = RST_GP;
    end

    // Almost flags straight from the count; bit 9 is compared as written
    next_s.flags[FL_DAE] = down_fill_i <= {1'b0, s.dae};
    next_s.flags[FL_DAF] = down_fill_i >= (FIFO_DEPTH - {1'b0, s.daf});
    next_s.flags[FL_UAE] = up_fill_i <= {1'b0, s.uae};
    next_s.flags[FL_UAF] = up_fill_i >= (FIFO_DEPTH - {1'b0, s.uaf});

    // Empty and full go through one more stage so they never coincide
    next_s.cmp_ef = {up_fill_i == FIFO_DEPTH,
                     up_empty_cnt == 11'h000,
                     down_full_cnt == FIFO_DEPTH,
                     down_fill_i == 11'h000};
    next_s.flags[FL_DE] = s.cmp_ef[0];
    next_s.flags[FL_DF] = s.cmp_ef[1];
    next_s.flags[FL_UE] = s.cmp_ef[2];
    next_s.flags[FL_UF] = s.cmp_ef[3];

    // Flag pins, one routing nibble each, A in the low nibble
    for (int i = 0; i < 4; i++) begin
      next_s.pins[i] = route_sel(s.route[4*i +: 4], s.flags);
    end

    // Rising flags are events; a clearing read loses to a new event
    rise = next_s.flags & ~s.flags;
    if (rd_now && byte_adr == OFS_IRQ_STAT) begin
      next_s.irq_st = rise;
    end else begin
      next_s.irq_st = s.irq_st | rise;
    end
    next_s.irq = |(next_s.irq_st & next_s.irq_mask);

    // Events of the taking cycle land before the clear, so report them too
    if (req_hit && !s.ack && byte_adr == OFS_IRQ_STAT) begin
      next_s.rdata = {8'h00, s.irq_st | rise};
    end

    // Pin filter: a bit moves only once stages two and three agree
    next_s.sync1    = {dma_req_pin_i, gp_pin_i};
    next_s.sync2    = s.sync1;
    next_s.sync3    = s.sync2;
    next_s.sync_val = (s.sync2 & ~(s.sync2 ^ s.sync3)) |
                      (s.sync_val & (s.sync2 ^ s.sync3));

    // Pin polarity, request active low when set, ack active high when set
    next_s.req     = s.sync_val[6] ^ s.ctrl[CTL_REQ_POL];
    next_s.ack_pin = dma_ack_int_i ^ ~s.ctrl[CTL_ACK_POL];

    // Internal DMA clock enable, every clock or every other one
    next_s.div  = ~s.div;
    next_s.tick = ~s.ctrl[CTL_CLK_DIV] | s.div;

    // Sequencer timing counts decoded from the control word
    next_s.req_ack_clks = REQ_ACK_BASE +
                          {1'b0, s.ctrl[CTL_TIMING_LO +: 2]};
    next_s.strobe_clks  = STROBE_BASE +
                          {1'b0, s.ctrl[CTL_STROBE2]};
  end

  // Reset ignores the clock enable so the bank always comes up defined
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s          <= '0;
      s.dae      <= RST_OFFSET;
      s.daf      <= RST_OFFSET;
      s.uae      <= RST_OFFSET;
      s.uaf      <= RST_OFFSET;
      s.route    <= RST_ROUTE;
      s.ctrl     <= RST_CTRL;
      s.gp_data  <= RST_GP;
      s.gp_dir   <= RST_GP;
      s.irq_mask <= RST_MASK;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  // Outputs, each a flop of the state
  assign wb_dat_o         = {16'h0000, s.rdata};
  assign wb_ack_o         = s.ack;
  assign dma_req_o        = s.req;
  assign dma_ack_pin_o    = s.ack_pin;
  assign gp_pin_o         = s.gp_data;
  assign gp_pin_oe_o      = s.gp_dir;
  assign flag_pin_a_o     = s.pins[0];
  assign flag_pin_b_o     = s.pins[1];
  assign flag_pin_c_o     = s.pins[2];
  assign flag_pin_d_o     = s.pins[3];
  assign port2_ds_style_o = s.ctrl[CTL_DS_STYLE];
  assign port2_ctrl_oe_o  = s.ctrl[CTL_PERIPH];
  assign req_ack_clocks_o = s.req_ack_clks;
  assign strobe_clocks_o  = s.strobe_clks;
  assign dma_tick_o       = s.tick;
  assign irq_o            = s.irq;

  // Checks on the bank's own behaviour
  a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && ce_i) |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i && ce_i))
    else $error("ack without a request");
  a_offsets_reset: assert property (@(posedge clk_i)
    $past(rst_i) |-> (s.dae == 10'h000 && s.uaf == 10'h000 &&
                      s.route == RST_ROUTE))
    else $error("offsets not cleared by reset");
  a_empty_lags_cmp: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ($past(ce_i) && $past(ce_i, 2) && !$past(rst_i, 2)) |->
      s.flags[FL_DE] == $past(down_fill_i == 11'h000, 2))
    else $error("empty flag timing wrong");
  a_almost_empty_cnt: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ($past(ce_i) && !$past(rst_i)) |-> s.flags[FL_DAE] ==
      ($past(down_fill_i) <= {1'b0, $past(s.dae)}))
    else $error("almost-empty threshold wrong");
  a_pin_a_route: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(ce_i) && !$past(rst_i)) |-> flag_pin_a_o ==
      $past(s.flags[s.route[2:0]]))
    else $error("flag pin A routing wrong");
  a_pin_d_route: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(ce_i) && !$past(rst_i)) |-> flag_pin_d_o ==
      $past(s.flags[s.route[14:12]]))
    else $error("flag pin D routing wrong");
  a_status_dir_bit: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ($rose(wb_ack_o) && $past(byte_adr == OFS_STATUS && !wb_we_i)) |->
      (wb_dat_o[ST_DMA_DIR] == $past(dma_dir_i) &&
       wb_dat_o[ST_UE] == $past(s.flags[FL_UE]) && wb_dat_o[2:0] == 3'h0))
    else $error("status word layout wrong");
  a_ack_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(ce_i) && !$past(rst_i)) |-> dma_ack_pin_o ==
      ($past(dma_ack_int_i) ^ !$past(s.ctrl[CTL_ACK_POL])))
    else $error("ack pin polarity wrong");
  a_full_def_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(ce_i) && $past(s.ctrl[CTL_FULL_DEF])) |->
      s.cmp_ef[1] == ($past(down_fill_reread_i) == FIFO_DEPTH))
    else $error("full definition select wrong");
  a_irq_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(rd_now && byte_adr == OFS_IRQ_STAT && ce_i) &&
     $past(next_s.flags == s.flags)) |-> s.irq_st == 8'h00)
    else $error("interrupt status not cleared by read");
  a_irq_event_set: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(ce_i && !rst_i) |-> ((s.irq_st & $past(rise)) == $past(rise)))
    else $error("flag event did not set interrupt status");
  a_pin_filter: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(ce_i) && !$past(rst_i) && $past(s.sync2 == s.sync3)) |->
      s.sync_val == $past(s.sync2))
    else $error("pin filter did not follow agreeing stages");
  a_tick_full: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(ce_i) && !$past(rst_i) && !$past(s.ctrl[CTL_CLK_DIV])) |->
      dma_tick_o)
    else $error("DMA tick missing while undivided");

endmodule : dual_fifo_flag_config_regs

// file: inc/dual_fifo_pkg.sv
// Constants shared by the dual FIFO flag and configuration register bank.
// Assumes a 32-bit classic Wishbone bus; registers sit in the low 16 bits.
package dual_fifo_pkg;

  // Register byte offsets, one aligned word each
  localparam logic [5:0] OFS_STATUS   = 6'h00;
  localparam logic [5:0] OFS_DOWN_AE  = 6'h04;
  localparam logic [5:0] OFS_DOWN_AF  = 6'h08;
  localparam logic [5:0] OFS_UP_AE    = 6'h0C;
  localparam logic [5:0] OFS_UP_AF    = 6'h10;
  localparam logic [5:0] OFS_ROUTE    = 6'h14;
  localparam logic [5:0] OFS_CTRL     = 6'h18;
  localparam logic [5:0] OFS_GP_DATA  = 6'h1C;
  localparam logic [5:0] OFS_GP_DIR   = 6'h20;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h24;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h28;

  // Reset values
  localparam logic [9:0]  RST_OFFSET = 10'h000;
  localparam logic [15:0] RST_ROUTE  = 16'h6420;
  localparam logic [10:0] RST_CTRL   = 11'h000;
  localparam logic [5:0]  RST_GP     = 6'h00;
  localparam logic [7:0]  RST_MASK   = 8'h00;

  // General control field positions
  localparam int CTL_DS_STYLE  = 0;
  localparam int CTL_FULL_DEF  = 2;
  localparam int CTL_EMPTY_DEF = 3;
  localparam int CTL_REQ_POL   = 4;
  localparam int CTL_ACK_POL   = 5;
  localparam int CTL_TIMING_LO = 6;
  localparam int CTL_STROBE2   = 8;
  localparam int CTL_CLK_DIV   = 9;
  localparam int CTL_PERIPH    = 10;

  // Internal flag index, equal to the low three bits of a routing code
  localparam int FL_DE  = 0;
  localparam int FL_DAE = 1;
  localparam int FL_DF  = 2;
  localparam int FL_DAF = 3;
  localparam int FL_UE  = 4;
  localparam int FL_UAE = 5;
  localparam int FL_UF  = 6;
  localparam int FL_UAF = 7;

  // Status word bit positions
  localparam int ST_DMA_DIR = 3;
  localparam int ST_DE      = 4;
  localparam int ST_DAE     = 5;
  localparam int ST_UF      = 6;
  localparam int ST_UAF     = 7;
  localparam int ST_DF      = 12;
  localparam int ST_DAF     = 13;
  localparam int ST_UE      = 14;
  localparam int ST_UAE     = 15;

  // FIFO depth and timing base
  localparam logic [10:0] FIFO_DEPTH   = 11'h400;
  localparam logic [2:0]  REQ_ACK_BASE = 3'h2;
  localparam logic [1:0]  STROBE_BASE  = 2'h1;

endpackage : dual_fifo_pkg

// file: test/tb_dual_fifo_flag_config_regs.sv
// Self-checking bench for the dual FIFO flag and configuration bank.
// Assumes wb_host_model on the register bus and a 25 MHz clock.
`timescale 1ns/1ps
module tb_dual_fifo_flag_config_regs;
  import dual_fifo_pkg::*;
  localparam int D = int'(FIFO_DEPTH);
  logic        clk_i, rst_i, cyc, stb, we, ack, go, hwe, done, dir, rall;
  logic        rqp, aki, rq, akp, pa, pb, pc, pd, dss, coe, tick, irq, t;
  logic [5:2]  adr, hadr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, hdat, hrd, r;
  logic [10:0] df, drr, uf, urw;
  logic [5:0]  gpi, gpo, gpoe, gd, gm;
  logic [2:0]  rac;
  logic [1:0]  stc;
  logic [9:0]  ofs [4];
  logic [15:0] ctl, v, route;
  logic [7:0]  f0;
  int          errors = 0, n_tests = 0, ncyc = 0, ta, tb_;

  // 40 ns clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  dual_fifo_flag_config_regs dut (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .down_fill_i(df), .down_fill_reread_i(drr),
    .up_fill_i(uf), .up_fill_rewrite_i(urw), .dma_dir_i(dir),
    .reset_all_i(rall), .dma_req_pin_i(rqp), .dma_ack_int_i(aki),
    .dma_req_o(rq), .dma_ack_pin_o(akp), .gp_pin_i(gpi), .gp_pin_o(gpo),
    .gp_pin_oe_o(gpoe), .flag_pin_a_o(pa), .flag_pin_b_o(pb),
    .flag_pin_c_o(pc), .flag_pin_d_o(pd), .port2_ds_style_o(dss),
    .port2_ctrl_oe_o(coe), .req_ack_clocks_o(rac), .strobe_clocks_o(stc),
    .dma_tick_o(tick), .irq_o(irq));

  wb_host_model host (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .we_i(hwe),
    .adr_i(hadr), .dat_i(hdat), .ack_i(ack), .rd_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat),
    .done_o(done), .rdata_o(hrd));

  // Expected internal flags from fill counts, offsets and control bits
  function automatic logic [7:0] flags();
    flags[0] = df == 0;
    flags[1] = df <= ofs[0];
    flags[2] = (ctl[2] ? drr : df) == D;
    flags[3] = df >= D - ofs[1];
    flags[4] = (ctl[3] ? urw : uf) == 0;
    flags[5] = uf <= ofs[2];
    flags[6] = uf == D;
    flags[7] = uf >= D - ofs[3];
  endfunction : flags

  // Fill count biased to the threshold edges
  function automatic logic [10:0] pick(int n, int m);
    int c [8];
    c = '{0, 1, n, n + 1, D - m - 1, D - m, D - 1, D};
    return 11'($urandom % 3 ? c[$urandom % 8] : $urandom % (D + 1));
  endfunction : pick

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : settle

  // One bus cycle through the host model; upper data lanes are noise
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [15:0] d, output logic [31:0] q);
    int k;
    @(posedge clk_i);
    hwe <= w;
    hadr <= a[5:2];
    hdat <= {16'($urandom), d};
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (done !== 1'b1 && k < 20);
    check(done, 1'b1);
    q = hrd;
  endtask : bus

  task automatic results();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  // Hang guard
  always @(posedge clk_i) begin
    ncyc++;
    if (ncyc == 40000) begin
      errors++;
      results();
    end
  end

  initial begin
    void'($urandom(32'h0CB386C3));
    {rst_i, go, hwe, hadr, hdat, dir, rall, rqp, aki, gpi} = '0;
    rst_i = 1'b1;
    {df, drr, uf, urw, ctl} = '0;
    foreach (ofs[i]) ofs[i] = 10'h0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values and unmapped space; irq status skipped, flags may fire
    for (int a = 4; a < 64; a += 4)
      if (a != 36) begin
        bus(1'b0, 6'(a), 16'h0, r);
        check(r, a == 20 ? 32'h6420 : 32'h0);
      end
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      bus(1'b1, 6'(4 + 4 * i), v, r);
      bus(1'b0, 6'(4 + 4 * i), 16'h0, r);
      check(r, {22'h0, v[9:0]});
    end
    // Control fields reach the port outputs, every timing code
    for (int j = 0; j < 8; j++) begin
      v = 16'($urandom);
      v[7:6] = j[1:0];
      v[9] = j[2];
      bus(1'b1, OFS_CTRL, v, r);
      ctl = v & 16'h07FD;
      bus(1'b0, OFS_CTRL, 16'h0, r);
      check(r, {16'h0, ctl});
      aki <= 1'($urandom);
      rqp <= 1'($urandom);
      settle(6);
      check(dss, ctl[0]);
      check(coe, ctl[10]);
      check(rac, 3'h2 + ctl[7:6]);
      check(stc, 2'h1 + ctl[8]);
      check(akp, 1'(aki ^ ~ctl[5]));
      check(rq, 1'(rqp ^ ctl[4]));
      t = tick;
      @(posedge clk_i);
      check(tick, ctl[9] ? 1'(~t) : 1'b1);
    end
    // Flags, status word and routing; all 16 codes on pin A first
    for (int k = 0; k < 32; k++) begin
      for (int i = 0; i < 4; i++) begin
        ofs[i] = 10'($urandom % 512);
        bus(1'b1, 6'(4 + 4 * i), {6'h0, ofs[i]}, r);
      end
      ctl = 16'($urandom) & 16'h07FD;
      bus(1'b1, OFS_CTRL, ctl, r);
      route = k < 16 ? {4'(k + 3), 4'(k + 2), 4'(k + 1), 4'(k)}
                     : 16'($urandom);
      bus(1'b1, OFS_ROUTE, route, r);
      df <= pick(ofs[0], ofs[1]);
      drr <= pick(ofs[0], ofs[1]);
      uf <= pick(ofs[2], ofs[3]);
      urw <= pick(ofs[2], ofs[3]);
      dir <= 1'($urandom);
      settle(6);
      bus(1'b0, OFS_STATUS, 16'h0, r);
      f0 = flags();
      check(r, {16'h0, f0[5:2], 4'h0, f0[7:6], f0[1:0], dir, 3'h0});
      check({pd, pc, pb, pa}, {f0[route[14:12]], f0[route[10:8]],
            f0[route[6:4]], f0[route[2:0]]});
    end
    // Pin direction and data
    for (int i = 0; i < 4; i++) begin
      gd = 6'($urandom);
      gm = 6'($urandom);
      bus(1'b1, OFS_GP_DATA, {10'h0, gd}, r);
      bus(1'b1, OFS_GP_DIR, {10'h0, gm}, r);
      gpi <= 6'($urandom);
      settle(6);
      check({gpoe, gpo}, {gm, gd});
      bus(1'b0, OFS_GP_DATA, 16'h0, r);
      check(r, (gd & gm) | (gpi & ~gm));
    end
    // Interrupt raised, read-cleared, then masked off
    {df, drr, uf, urw} <= {4{11'h200}};
    bus(1'b1, OFS_IRQ_MASK, 16'h00FF, r);
    settle(6);
    bus(1'b0, OFS_IRQ_STAT, 16'h0, r);
    settle(2);
    f0 = flags();
    check(irq, 1'b0);
    df <= 11'h0;
    settle(6);
    f0 = flags() & ~f0;
    check(irq, 1'b1);
    bus(1'b0, OFS_IRQ_STAT, 16'h0, r);
    check(r, {24'h0, f0});
    bus(1'b0, OFS_IRQ_STAT, 16'h0, r);
    check(r, 32'h0);
    settle(2);
    check(irq, 1'b0);
    bus(1'b1, OFS_IRQ_MASK, 16'h0, r);
    {uf, urw} <= 22'h0;
    settle(6);
    check(irq, 1'b0);
    // Software reset-all, then empty must trail almost-empty
    rall <= 1'b1;
    @(posedge clk_i);
    rall <= 1'b0;
    for (int a = 4; a < 28; a += 4) begin
      bus(1'b0, 6'(a), 16'h0, r);
      check(r, a == 20 ? 32'h6420 : 32'h0);
    end
    ctl = 16'h0;
    foreach (ofs[i]) ofs[i] = 10'h0;
    bus(1'b1, OFS_ROUTE, 16'h0010, r);
    df <= 11'h1;
    settle(6);
    df <= 11'h0;
    ta = 0;
    tb_ = 0;
    for (int s = 1; s < 9; s++) begin
      @(posedge clk_i);
      if (pa === 1'b1 && ta == 0) ta = s;
      if (pb === 1'b1 && tb_ == 0) tb_ = s;
    end
    check(ta, tb_ + 1);
    results();
  end
endmodule : tb_dual_fifo_flag_config_regs

// file: test/wb_host_model.sv
// Host processor model on the classic Wishbone control port.
// Assumes the bench pulses go_i for one cycle and waits for done_o.
`timescale 1ns/1ps
module wb_host_model #(
  parameter bit SHALLOW = 1'b0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic        we_i,
  input  wire logic [5:2]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rd_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [5:2]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o,
  output logic             done_o,
  output logic      [31:0] rdata_o
);
  // Request held until ack is sampled; idle data lines toggle so no stale value
  // can pass for a driven one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= 1'b0;
      adr_o <= 4'h0;
      sel_o <= 4'hF;
      dat_o <= 32'h0;
      done_o <= 1'b0;
      rdata_o <= 32'h0;
    end else if (!cyc_o) begin
      done_o <= 1'b0;
      dat_o <= ~dat_o;
      if (go_i) begin
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= we_i;
        adr_o <= adr_i;
        dat_o <= dat_i;
        // Shallow part only: offset bit 9 must go out as zero
        if (SHALLOW && adr_i inside {[4'h1:4'h4]}) dat_o[9] <= 1'b0;
      end
    end else if (ack_i) begin
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      done_o <= 1'b1;
      rdata_o <= rd_i;
    end
  end
endmodule : wb_host_model
